// ---- verilog/crsd_space_decode.sv ----
// Data-memory space decoder: user RAM plus the control register window.
// Assumes one CPU core issues at most one access per enabled cycle.
//
// What this block does
// - Control registers decode only in the window 0C0h to 0FFh.
// - Data space splits into user RAM with stack, and the register window.
// - User RAM holds 330 bytes for data and stack.
// - Unmapped window reads return a fixed filler, which software cannot trust.
// - Byte-and-bit registers accept bit operations, merged into the read value; a port latch takes the pin level on input bits.
// - One address may carry two names: reads see one function, writes another.
// - A direction bit of one drives the pin; zero leaves it input.
// - The core starts from the two-byte reset vector at the top.
// - Each interrupt source has a fixed two-byte vector, key scan at FA.
`timescale 1ns/100ps
module crsd_space_decode
    import crsd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [8:0]  addr,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wdata,
    input  wire logic        bit_wr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        bit_val,
    output logic      [7:0]  rdata,
    output logic             rd_valid,
    input  wire logic [7:0]  port0_pin_in,
    output logic      [7:0]  port0_pin_out,
    output logic      [7:0]  port0_pin_oe,
    input  wire logic [7:0]  port1_pin_in,
    output logic      [7:0]  port1_pin_out,
    output logic      [7:0]  port1_pin_oe,
    input  wire logic [7:0]  port2_pin_in,
    output logic      [7:0]  port2_pin_out,
    output logic      [7:0]  port2_pin_oe,
    input  wire logic [7:0]  converter_result,
    input  wire logic [7:0]  timer1_count,
    output logic      [7:0]  power_save_mode_ctrl,
    output logic      [7:0]  converter_mode_ctrl,
    output logic      [7:0]  clock_divider_ctrl,
    output logic      [7:0]  key_line_select_low,
    output logic      [7:0]  key_line_select_high,
    output logic      [7:0]  port0_pullup_select,
    output logic      [7:0]  port2_pullup_select,
    output logic      [7:0]  port3_pullup_select,
    output logic      [5:0]  port4_pullup_select,
    input  wire logic [3:0]  vector_sel,
    output logic      [15:0] vector_addr,
    output logic      [15:0] reset_fetch_addr
);

    // True for addresses that land in user RAM, below or above the window.
    function automatic logic is_ram(input logic [8:0] a);
        return (a < WIN_LO) || ((a > WIN_HI) && (a <= RAM_HI));
    endfunction : is_ram

    // Folds the RAM address around the window into a dense index.
    function automatic logic [8:0] ram_index(input logic [8:0] a);
        return (a < WIN_LO) ? a : 9'(a - RAM_GAP);
    endfunction : ram_index

    // Port read value: driven pins show the latch, inputs show the pin.
    function automatic logic [7:0] port_rd(input logic [7:0] dir,
                                           input logic [7:0] lat,
                                           input logic [7:0] pin);
        return (dir & lat) | (~dir & pin);
    endfunction : port_rd

    logic [7:0]  ram [RAM_WORDS];
    logic [7:0]  p0_dir, p1_dir, p2_dir;
    logic [7:0]  next_p0_dat, next_p1_dat, next_p2_dat;
    logic [7:0]  next_p0_dir, next_p1_dir, next_p2_dir;
    logic [7:0]  next_pwr, next_conv, next_clkdiv, next_keyl, next_keyh;
    logic [7:0]  next_pu0, next_pu2, next_pu3;
    logic [5:0]  next_pu4;
    logic [7:0]  next_rdata;
    logic        next_rd_valid;
    logic [15:0] next_vector;
    logic [7:0]  cur_byte;
    logic        bit_ok;
    logic        do_wr;
    logic [7:0]  wr_byte;

    // Current byte at the address and whether it accepts bit operations.
    always_comb begin
        cur_byte = RD_FILL;
        bit_ok   = 1'b0;
        if (is_ram(addr)) begin
            cur_byte = ram[ram_index(addr)];
            bit_ok   = 1'b1;
        end else begin
            case (addr)
                OFS_P0_DATA: begin
                    cur_byte = port_rd(p0_dir, port0_pin_out, port0_pin_in);
                    bit_ok   = 1'b1;
                end
                OFS_P1_DATA: begin
                    cur_byte = port_rd(p1_dir, port1_pin_out, port1_pin_in);
                    bit_ok   = 1'b1;
                end
                OFS_P2_DATA: begin
                    cur_byte = port_rd(p2_dir, port2_pin_out, port2_pin_in);
                    bit_ok   = 1'b1;
                end
                OFS_CONV_MODE: begin
                    cur_byte = converter_mode_ctrl;
                    bit_ok   = 1'b1;
                end
                OFS_CONV_RES: cur_byte = converter_result;
                OFS_CLK_DIV:  cur_byte = timer1_count;
                default:      cur_byte = RD_FILL;
            endcase
        end
    end

    // A byte write wins; a bit write merges one bit into the current byte.
    always_comb begin
        do_wr   = ce && (wr_en || (bit_wr && bit_ok));
        wr_byte = wdata;
        if (!wr_en) begin
            wr_byte          = cur_byte;
            wr_byte[bit_sel] = bit_val;
        end
    end

    // Next values of the register window and the read path.
    always_comb begin
        next_p0_dat = port0_pin_out;
        next_p1_dat = port1_pin_out;
        next_p2_dat = port2_pin_out;
        next_p0_dir = p0_dir;
        next_p1_dir = p1_dir;
        next_p2_dir = p2_dir;
        next_pwr    = power_save_mode_ctrl;
        next_conv   = converter_mode_ctrl;
        next_clkdiv = clock_divider_ctrl;
        next_keyl   = key_line_select_low;
        next_keyh   = key_line_select_high;
        next_pu0    = port0_pullup_select;
        next_pu2    = port2_pullup_select;
        next_pu3    = port3_pullup_select;
        next_pu4    = port4_pullup_select;
        if (do_wr) begin
            case (addr)
                OFS_P0_DATA:   next_p0_dat = wr_byte;
                OFS_P1_DATA:   next_p1_dat = wr_byte;
                OFS_P2_DATA:   next_p2_dat = wr_byte;
                OFS_CONV_MODE: next_conv   = wr_byte;
                default:       next_conv   = converter_mode_ctrl;
            endcase
        end
        // Byte-only registers change on whole-byte writes alone.
        if (ce && wr_en) begin
            case (addr)
                OFS_P0_DIR:   next_p0_dir = wdata;
                OFS_P1_DIR:   next_p1_dir = wdata;
                OFS_P2_DIR:   next_p2_dir = wdata;
                OFS_CLK_DIV:  next_clkdiv = wdata;
                OFS_PWR_SAVE: next_pwr    = wdata;
                OFS_KEY_LOW:  next_keyl   = wdata;
                OFS_KEY_HIGH: next_keyh   = wdata;
                OFS_P0_PULL:  next_pu0    = wdata;
                OFS_P2_PULL:  next_pu2    = wdata;
                OFS_P3_PULL:  next_pu3    = wdata;
                OFS_P4_PULL:  next_pu4    = wdata[5:0];
                default:      next_pu4    = port4_pullup_select;
            endcase
        end
        next_rd_valid = ce && rd_en;
        next_rdata    = (ce && rd_en) ? cur_byte : rdata;
        next_vector   = VEC_BASE + {11'h000, vector_sel, 1'b0};
    end

    // Registers of the window; ce low freezes everything.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            port0_pin_out        <= RST_ZERO;
            port1_pin_out        <= RST_ZERO;
            port2_pin_out        <= RST_ZERO;
            p0_dir               <= RST_ZERO;
            p1_dir               <= RST_ZERO;
            p2_dir               <= RST_ZERO;
            power_save_mode_ctrl <= RST_ZERO;
            converter_mode_ctrl  <= RST_CONV_MODE;
            clock_divider_ctrl   <= RST_ZERO;
            key_line_select_low  <= RST_ZERO;
            key_line_select_high <= RST_ZERO;
            port0_pullup_select  <= RST_ZERO;
            port2_pullup_select  <= RST_ZERO;
            port3_pullup_select  <= RST_ZERO;
            port4_pullup_select  <= RST_P4_PULL;
            rdata                <= RST_ZERO;
            rd_valid             <= 1'b0;
            vector_addr          <= VEC_RESET;
        end else if (ce) begin
            port0_pin_out        <= next_p0_dat;
            port1_pin_out        <= next_p1_dat;
            port2_pin_out        <= next_p2_dat;
            p0_dir               <= next_p0_dir;
            p1_dir               <= next_p1_dir;
            p2_dir               <= next_p2_dir;
            power_save_mode_ctrl <= next_pwr;
            converter_mode_ctrl  <= next_conv;
            clock_divider_ctrl   <= next_clkdiv;
            key_line_select_low  <= next_keyl;
            key_line_select_high <= next_keyh;
            port0_pullup_select  <= next_pu0;
            port2_pullup_select  <= next_pu2;
            port3_pullup_select  <= next_pu3;
            port4_pullup_select  <= next_pu4;
            rdata                <= next_rdata;
            rd_valid             <= next_rd_valid;
            vector_addr          <= next_vector;
        end
    end

    // User RAM has no reset; contents are undefined until written.
    always_ff @(posedge clk) begin
        if (do_wr && is_ram(addr)) begin
            ram[ram_index(addr)] <= wr_byte;
        end
    end

    // Pins: a set direction bit drives the latched level out.
    assign port0_pin_oe     = p0_dir;
    assign port1_pin_oe     = p1_dir;
    assign port2_pin_oe     = p2_dir;
    assign reset_fetch_addr = VEC_RESET;

    // Checks of the decoder behaviour.
    dir_reset_a: assert property (@(posedge clk)
        !resetn |=> (port0_pin_oe == 8'h00) && (port2_pin_oe == 8'h00))
        else $error("Direction not cleared by reset.");
    rd_latency_a: assert property (@(posedge clk) disable iff (!resetn)
        ce |=> rd_valid == $past(rd_en))
        else $error("Read answer not one cycle after request.");
    ram_rw_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && wr_en && is_ram(addr) ##1 !wr_en && !bit_wr ##1
        ce && rd_en && !wr_en && !bit_wr && addr == $past(addr, 2)
        |=> rdata == $past(wdata, 3))
        else $error("RAM read does not return written byte.");
    unmapped_rd_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && rd_en && addr == 9'h0_E9 |=> rdata == RD_FILL)
        else $error("Unmapped read returns wrong filler.");
    wo_read_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && rd_en && !wr_en && addr == OFS_P1_DIR
        |=> $stable(port1_pin_oe) && rdata == RD_FILL)
        else $error("Write-only read disturbed register.");
    bit_merge_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && bit_wr && !wr_en && addr == OFS_CONV_MODE
        |=> converter_mode_ctrl[$past(bit_sel)] == $past(bit_val))
        else $error("Bit write not merged.");
    byte_only_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && bit_wr && !wr_en && addr == OFS_P0_DIR |=> $stable(port0_pin_oe))
        else $error("Bit write changed byte-only register.");
    alias_rd_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && rd_en && addr == OFS_CLK_DIV |=> rdata == $past(timer1_count))
        else $error("Shared address read wrong source.");
    dir_write_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && wr_en && addr == OFS_P2_DIR |=> port2_pin_oe == $past(wdata))
        else $error("Direction write not applied.");
    vector_a: assert property (@(posedge clk) disable iff (!resetn)
        ce && vector_sel == 4'hD |=> vector_addr == VEC_KEY_SCAN)
        else $error("Key scan vector wrong.");
    freeze_a: assert property (@(posedge clk) disable iff (!resetn)
        !ce |=> $stable(rdata) && $stable(converter_mode_ctrl))
        else $error("State moved while clock enable low.");
    cover property (@(posedge clk) ce && wr_en && addr == OFS_P0_DIR);
    cover property (@(posedge clk) ce && bit_wr && addr == OFS_P0_DATA);
    cover property (@(posedge clk) ce && rd_en && addr == RAM_HI);

endmodule : crsd_space_decode

// ---- common/crsd_pkg.sv ----
// Constants for the data-memory space decoder: map, offsets, resets.
// Assumes a single 9-bit data address space driven by the CPU core.
package crsd_pkg;
    localparam int          ADDR_W         = 9;
    localparam int          RAM_WORDS      = 330;
    localparam int          RAM_IDX_W      = 9;
    // Control register window bounds.
    localparam logic [8:0]  WIN_LO         = 9'h0_C0;
    localparam logic [8:0]  WIN_HI         = 9'h0_FF;
    // Highest RAM address above the window; RAM below it starts at zero.
    localparam logic [8:0]  RAM_HI         = 9'h1_89;
    localparam logic [8:0]  RAM_GAP        = 9'h0_40;
    // Register offsets.
    localparam logic [8:0]  OFS_P0_DATA    = 9'h0_C0;
    localparam logic [8:0]  OFS_P0_DIR     = 9'h0_C1;
    localparam logic [8:0]  OFS_P1_DATA    = 9'h0_C2;
    localparam logic [8:0]  OFS_P1_DIR     = 9'h0_C3;
    localparam logic [8:0]  OFS_P2_DATA    = 9'h0_C4;
    localparam logic [8:0]  OFS_P2_DIR     = 9'h0_C5;
    localparam logic [8:0]  OFS_CLK_DIV    = 9'h0_C7;
    localparam logic [8:0]  OFS_PWR_SAVE   = 9'h0_F0;
    localparam logic [8:0]  OFS_CONV_MODE  = 9'h0_F4;
    localparam logic [8:0]  OFS_CONV_RES   = 9'h0_F5;
    localparam logic [8:0]  OFS_KEY_LOW    = 9'h0_F6;
    localparam logic [8:0]  OFS_KEY_HIGH   = 9'h0_F7;
    localparam logic [8:0]  OFS_P0_PULL    = 9'h0_F8;
    localparam logic [8:0]  OFS_P2_PULL    = 9'h0_FA;
    localparam logic [8:0]  OFS_P3_PULL    = 9'h0_FB;
    localparam logic [8:0]  OFS_P4_PULL    = 9'h0_FC;
    // Reset values.
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  RST_CONV_MODE  = 8'h01;
    localparam logic [5:0]  RST_P4_PULL    = 6'h00;
    // Value returned for unmapped or write-only reads.
    localparam logic [7:0]  RD_FILL        = 8'h00;
    // Program-memory vectors.
    localparam logic [15:0] VEC_BASE       = 16'hFF_E0;
    localparam logic [15:0] VEC_RESET      = 16'hFF_FE;
    localparam logic [15:0] VEC_KEY_SCAN   = 16'hFF_FA;
endpackage : crsd_pkg

// ---- testbench/crsd_cpu_model.sv ----
// CPU core model that issues byte writes, bit writes and reads.
// Assumes the decoder answers a read one enabled cycle after the request.
`timescale 1ns/100ps
module crsd_cpu_model
    import crsd_pkg::*;
(
    input  wire logic       clk,
    output logic            ce,
    output logic [8:0]      addr,
    output logic            rd_en,
    output logic            wr_en,
    output logic [7:0]      wdata,
    output logic            bit_wr,
    output logic [2:0]      bit_sel,
    output logic            bit_val,
    input  wire logic [7:0] rdata,
    input  wire logic       rd_valid
);
    // The bus starts idle with the clock enable held on.
    initial begin
        ce = 1'b1;
        addr = 9'h000;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 8'h00;
        bit_wr = 1'b0;
        bit_sel = 3'h0;
        bit_val = 1'b0;
    end

    // Bit operations are allowed on every address outside the window and on the byte-and-bit registers.
    function automatic logic bit_ok(input logic [8:0] a);
        bit_ok = (a < WIN_LO) || (a > WIN_HI) || (a == OFS_P0_DATA) ||
                 (a == OFS_P1_DATA) || (a == OFS_P2_DATA) ||
                 (a == OFS_CONV_MODE);
    endfunction : bit_ok

    // Drops the request and scrambles the released address and data.
    task automatic idle(input logic [8:0] a, input logic [7:0] d);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        bit_wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : idle

    // Whole-byte write; the only kind that changes write-only registers.
    task automatic write_byte(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        idle(a, d);
        #1;
    endtask : write_byte

    // Single-bit write, never issued to a byte-only location.
    task automatic write_bit(input logic [8:0] a, input logic [2:0] s,
                             input logic b);
        if (bit_ok(a)) write_bit_any(a, s, b);
    endtask : write_bit

    // Holds a byte write with the clock enable low; nothing may land.
    task automatic stall(input logic [8:0] a, input logic [7:0] d,
                         input int n);
        @(posedge clk);
        ce <= 1'b0;
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        repeat (n) @(posedge clk);
        ce <= 1'b1;
        idle(a, d);
        #1;
    endtask : stall

    // Single-bit write to any location, used to probe the refusal path.
    task automatic write_bit_any(input logic [8:0] a, input logic [2:0] s,
                                 input logic b);
        @(posedge clk);
        addr <= a;
        bit_sel <= s;
        bit_val <= b;
        bit_wr <= 1'b1;
        @(posedge clk);
        idle(a, 8'h00);
        #1;
    endtask : write_bit_any

    // Byte read; returns the strobe and data seen after the taking edge.
    task automatic read_byte(input logic [8:0] a, output logic v,
                             output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        idle(a, 8'h00);
        #1;
        v = rd_valid;
        d = rdata;
    endtask : read_byte
endmodule : crsd_cpu_model

// ---- testbench/tb.sv ----
// Self-checking bench for the data-memory decoder.
// Assumes the CPU model drives the bus and the bench drives pins.
`timescale 1ns/100ps
module tb;
    import crsd_pkg::*;
    logic        clk, resetn, ce, rd_en, wr_en, bit_wr, bit_val, rd_valid, v;
    logic [8:0]  addr;
    logic [2:0]  bit_sel;
    logic [3:0]  vector_sel;
    logic [5:0]  port4_pullup_select;
    logic [15:0] vector_addr, reset_fetch_addr;
    logic [7:0]  wdata, rdata, d, port0_pin_in, port0_pin_out, port0_pin_oe;
    logic [7:0]  port1_pin_in, port1_pin_out, port1_pin_oe, port2_pin_in;
    logic [7:0]  port2_pin_out, port2_pin_oe, converter_result, timer1_count;
    logic [7:0]  power_save_mode_ctrl, converter_mode_ctrl, clock_divider_ctrl;
    logic [7:0]  key_line_select_low, key_line_select_high, port0_pullup_select;
    logic [7:0]  port2_pullup_select, port3_pullup_select;
    int          num_errors, n_tests;
    logic [8:0]  regs [12] = '{OFS_P0_DIR, OFS_P1_DIR, OFS_P2_DIR, OFS_CLK_DIV,
        OFS_PWR_SAVE, OFS_CONV_MODE, OFS_KEY_LOW, OFS_KEY_HIGH, OFS_P0_PULL,
        OFS_P2_PULL, OFS_P3_PULL, OFS_P4_PULL};
    logic [8:0]  ram [4] = '{9'h000, 9'h0BF, 9'h100, 9'h189};

    crsd_space_decode uut (.clk, .resetn, .ce, .addr, .rd_en, .wr_en, .wdata,
        .bit_wr, .bit_sel, .bit_val, .rdata, .rd_valid, .port0_pin_in,
        .port0_pin_out, .port0_pin_oe, .port1_pin_in, .port1_pin_out,
        .port1_pin_oe, .port2_pin_in, .port2_pin_out, .port2_pin_oe,
        .converter_result, .timer1_count, .power_save_mode_ctrl,
        .converter_mode_ctrl, .clock_divider_ctrl, .key_line_select_low,
        .key_line_select_high, .port0_pullup_select, .port2_pullup_select,
        .port3_pullup_select, .port4_pullup_select, .vector_sel, .vector_addr,
        .reset_fetch_addr);
    crsd_cpu_model cpu (.clk, .ce, .addr, .rd_en, .wr_en, .wdata, .bit_wr,
        .bit_sel, .bit_val, .rdata, .rd_valid);

    // Free-running 100 ns clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Maps a register address to the output that shows its stored value.
    function automatic logic [7:0] reg_out(input logic [8:0] a);
        case (a)
            OFS_P0_DIR:    reg_out = port0_pin_oe;
            OFS_P1_DIR:    reg_out = port1_pin_oe;
            OFS_P2_DIR:    reg_out = port2_pin_oe;
            OFS_CLK_DIV:   reg_out = clock_divider_ctrl;
            OFS_PWR_SAVE:  reg_out = power_save_mode_ctrl;
            OFS_CONV_MODE: reg_out = converter_mode_ctrl;
            OFS_KEY_LOW:   reg_out = key_line_select_low;
            OFS_KEY_HIGH:  reg_out = key_line_select_high;
            OFS_P0_PULL:   reg_out = port0_pullup_select;
            OFS_P2_PULL:   reg_out = port2_pullup_select;
            OFS_P3_PULL:   reg_out = port3_pullup_select;
            default:       reg_out = {2'b00, port4_pullup_select};
        endcase
    endfunction : reg_out

    // Counts one comparison and reports a mismatch.
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check

    // Reads one byte and checks both the strobe and the data.
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        cpu.read_byte(a, v, d);
        check("read strobe", 16'h0001, {15'h0000, v});
        check("read data", {8'h00, exp}, {8'h00, d});
    endtask : rd_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Cuts a hung run short.
    initial begin
        #10_000_000;
        num_errors++;
        close_out();
    end

    // Main sequence of bus calls and expected values.
    initial begin
        resetn = 1'b0;
        port0_pin_in = 8'h0F;
        port1_pin_in = 8'hC3;
        port2_pin_in = 8'h99;
        converter_result = 8'h3D;
        timer1_count = 8'h6B;
        vector_sel = 4'h0;
        num_errors = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        foreach (regs[i]) check("reset value", (regs[i] == OFS_CONV_MODE) ?
            RST_CONV_MODE : RST_ZERO, reg_out(regs[i]));
        check("reset fetch", 16'hFFFE, reset_fetch_addr);
        foreach (regs[i]) begin
            d = 8'hA0 + 8'(i);
            cpu.write_byte(regs[i], d);
            cpu.read_byte(regs[i], v, d);
            d = 8'hA0 + 8'(i);
            if (regs[i] == OFS_P4_PULL) d = {2'b00, d[5:0]};
            check("register output", d, reg_out(regs[i]));
        end
        foreach (ram[i]) begin
            cpu.write_byte(ram[i], 8'h30 + 8'(i));
            rd_chk(ram[i], 8'h30 + 8'(i));
        end
        foreach (ram[i]) rd_chk(ram[i], 8'h30 + 8'(i));
        cpu.write_byte(OFS_P0_DIR, 8'hA5);
        cpu.write_byte(OFS_P0_DATA, 8'h3C);
        rd_chk(OFS_P0_DATA, 8'h2E);
        check("pin out", 16'h003C, {8'h00, port0_pin_out});
        cpu.write_byte(9'h010, 8'h00);
        cpu.write_bit(9'h010, 3'd3, 1'b1);
        cpu.write_bit(9'h010, 3'd7, 1'b1);
        cpu.write_bit(9'h010, 3'd3, 1'b0);
        rd_chk(9'h010, 8'h80);
        cpu.write_byte(OFS_CONV_MODE, 8'h00);
        cpu.write_bit(OFS_CONV_MODE, 3'd0, 1'b1);
        cpu.write_bit(OFS_CONV_MODE, 3'd6, 1'b1);
        rd_chk(OFS_CONV_MODE, 8'h41);
        cpu.stall(OFS_CONV_MODE, 8'hFF, 3);
        check("frozen", 16'h0041, {8'h00, converter_mode_ctrl});
        cpu.write_byte(OFS_P1_DIR, 8'hFF);
        cpu.write_byte(OFS_P1_DATA, 8'h00);
        cpu.write_bit(OFS_P1_DATA, 3'd2, 1'b1);
        check("bit pin", 16'h0004, {8'h00, port1_pin_out});
        rd_chk(OFS_CLK_DIV, 8'h6B);
        check("alias", 16'h00A3, {8'h00, clock_divider_ctrl});
        rd_chk(OFS_CONV_RES, 8'h3D);
        cpu.read_byte(9'h0E9, v, d);
        check("gap strobe", 16'h0001, {15'h0000, v});
        check("gap data", {8'h00, RD_FILL}, {8'h00, d});
        check("gap state", 16'h00A5, {8'h00, port0_pin_oe});
        cpu.write_bit_any(OFS_P0_DIR, 3'd1, 1'b1);
        check("byte only", 16'h00A5, {8'h00, port0_pin_oe});
        for (int s = 0; s < 16; s++) begin
            @(posedge clk);
            vector_sel <= 4'(s);
            @(posedge clk);
            #1;
            check("vector", 16'hFFE0 + 16'(2 * s), vector_addr);
        end
        close_out();
    end
endmodule : tb
